// ### shared/supervision_pkg.sv
// constants, register map and status types of the voltage supervision block
//
// Overview of operation
// - four channel fundamental magnitudes are inputs, refreshed every 5 ms.
// - sequence voltages and every channel angle feed the supervision.
// - pick-up when one phase is low or two phases are high.
// - low threshold in 0.01 nominal steps, default 0.05 nominal.
// - high threshold in 0.01 nominal steps, default 0.80 nominal.
// - angle change over 40 ms below limit (default 5.0 deg) suppresses pick-up.
// - yes/no setting, default yes, supervises the bus breaker trip input.
// - yes/no setting, default yes, supervises the line breaker trip input.
// - ratio between threshold and measured magnitude computed per phase.
// - thresholds switch by setting group selection while supervision runs.
// - bus state is dead, ok, ok reversed, ok undefined, or problem.
// - problem bus state reported whenever pick-up holds.
// - condition is normal, started, line failure, bus failure or blocked.
// - expected operating time reported, 0 to 1800 s, 5 ms steps.
// - time left before operation counts down as signed value.
// - output serves as alarm and as disable for dependent functions.
// - block at pick-up gives blocked; block after start resets start.
// - definite time delay between pick-up and operation.
package supervision_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int ANGLE_WINDOW_MS = 40;
  localparam int HIST_DEPTH = ANGLE_WINDOW_MS / TICK_MS;
  localparam int TICK_CNT_W = 16;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int MAG_W = 12;
  localparam int ANG_W = 12;
  localparam logic [ANG_W-1:0] ANG_FULL = 12'hE10;
  localparam logic [ANG_W-1:0] ANG_HALF = 12'h708;
  localparam int DLY_W = 19;
  localparam int REM_W = 20;
  localparam int THR_W = 7;
  localparam int LIM_W = 10;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_GROUP0 = 8'h00;
  localparam logic [7:0] OFF_GROUP1 = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_DELAY = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OPTIME = 8'h14;
  localparam logic [7:0] OFF_REMAIN = 8'h18;
  localparam logic [7:0] OFF_RATIO0 = 8'h1C;
  localparam logic [7:0] OFF_RATIO1 = 8'h20;
  localparam logic [7:0] OFF_RATIO2 = 8'h24;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  localparam int LIM_LSB = 16;
  localparam logic [31:0] GROUP_MASK = 32'h03FF7F7F;
  localparam logic [31:0] GROUP_RST = 32'h00325005;
  localparam int CTRL_GRP = 0;
  localparam int CTRL_BUS = 1;
  localparam int CTRL_LINE = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam logic [DLY_W-1:0] DELAY_RST = 19'h000C8;
  localparam int COND_LSB = 0;
  localparam int BUS_LSB = 4;
  localparam int PICK_BIT = 8;
  localparam int START_BIT = 9;
  localparam int BLK_BIT = 10;
  localparam int ALARM_BIT = 11;
  // ---------------------------------------------------------------
  // status types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {COND_NORMAL, COND_STARTED, COND_LINE_FAIL, COND_BUS_FAIL,
                            COND_BLOCKED} cond_t;
  typedef enum logic [2:0] {BUS_DEAD, BUS_OK, BUS_REV, BUS_UNDEF, BUS_PROBLEM} bus_t;
endpackage

// ### shared/timer_if.sv
// carrier between the supervision top and its definite time delay
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
  logic tick;
  logic run;
  logic [supervision_pkg::DLY_W-1:0] delay;
  logic expired;
  logic signed [supervision_pkg::REM_W-1:0] remain;
  modport ctrl (output tick, output run, output delay, input expired, input remain);
  modport timer (input tick, input run, input delay, output expired, output remain);
endinterface
`default_nettype wire

// ### logic/op_timer.sv
// definite time delay with remaining time countdown
`timescale 1ns/1ns
`default_nettype none
module op_timer (
  input wire logic pclk,
  input wire logic presetn,
  timer_if.timer t
);
  import supervision_pkg::*;
  logic [DLY_W-1:0] elapsed_q, elapsed_d;
  logic expired_q, expired_d;
  logic signed [REM_W-1:0] remain_q, remain_d;

  // ---------------------------------------------------------------
  // countdown
  // ---------------------------------------------------------------
  // count ticks while running, restart on release
  always_comb begin
    elapsed_d = elapsed_q;
    if (!t.run) begin
      elapsed_d = '0;
    end else if (t.tick && elapsed_q < t.delay) begin
      elapsed_d = elapsed_q + 19'h00001;
    end
    expired_d = t.run && (elapsed_d >= t.delay);
    remain_d = REM_W'(signed'({1'b0, t.delay}) - signed'({1'b0, elapsed_d}));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_q <= '0;
      expired_q <= 1'b0;
      remain_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
      expired_q <= expired_d;
      remain_q <= remain_d;
    end
  end

  assign t.expired = expired_q;
  assign t.remain = remain_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_expire_after_delay;
    expired_q |-> $past(t.run) && elapsed_q >= $past(t.delay);
  endproperty
  a_expire_after_delay: assert property (p_expire_after_delay)
    else $error("delay expired early");

  property p_release_restarts;
    !t.run |=> elapsed_q == '0 && !expired_q;
  endproperty
  a_release_restarts: assert property (p_release_restarts)
    else $error("timer not reset on release");
endmodule
`default_nettype wire

// ### logic/angle_tracker.sv
// per channel angle history and 40 ms shift detection
`timescale 1ns/1ns
`default_nettype none
module angle_tracker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [3:0][supervision_pkg::ANG_W-1:0] angle,
  input wire logic [supervision_pkg::LIM_W-1:0] limit,
  output logic shift_seen
);
  import supervision_pkg::*;
  logic [3:0] big_q, big_d;

  // ---------------------------------------------------------------
  // one history line per channel
  // ---------------------------------------------------------------
  for (genvar c = 0; c < 4; c++) begin : g_chan
    logic [ANG_W-1:0] hist_q [HIST_DEPTH];
    logic [ANG_W-1:0] hist_d [HIST_DEPTH];
    logic [ANG_W-1:0] diff;
    // shift in on each tick, compare with value 40 ms old
    always_comb begin
      hist_d = hist_q;
      if (tick) begin
        hist_d[0] = angle[c];
        for (int i = 1; i < HIST_DEPTH; i++) begin
          hist_d[i] = hist_q[i-1];
        end
      end
      diff = angle[c] - hist_q[HIST_DEPTH-1];
      if (angle[c] < hist_q[HIST_DEPTH-1]) begin
        diff = diff + ANG_FULL; // wrap through 360 deg
      end
      if (diff > ANG_HALF) begin
        diff = ANG_FULL - diff;
      end
      big_d[c] = tick ? (diff >= ANG_W'(limit)) : big_q[c];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int i = 0; i < HIST_DEPTH; i++) begin
          hist_q[i] <= '0;
        end
      end else begin
        hist_q <= hist_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      big_q <= '0;
    end else begin
      big_q <= big_d;
    end
  end

  assign shift_seen = |big_q;
endmodule
`default_nettype wire

// ### logic/voltage_supervision.sv
// voltage transformer supervision top with apb register file
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module voltage_supervision #(
  parameter int TICK_CYCLES_P = supervision_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0][supervision_pkg::MAG_W-1:0] mag,
  input wire logic [3:0][supervision_pkg::ANG_W-1:0] angle,
  input wire logic [supervision_pkg::MAG_W-1:0] seq_pos,
  input wire logic [supervision_pkg::MAG_W-1:0] seq_neg,
  input wire logic [supervision_pkg::MAG_W-1:0] seq_zero,
  input wire logic bus_breaker_trip_input,
  input wire logic line_breaker_trip_input,
  input wire logic block_in,
  output logic alarm,
  output logic measurement_disable,
  output logic start,
  output logic blocked,
  output logic bus_transformer_failure,
  output logic line_transformer_failure
);
  import supervision_pkg::*;

  timer_if tif ();
  logic shift_seen;

  // ---------------------------------------------------------------
  // processing tick
  // ---------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  // one pulse every 5 ms drives the next-state evaluation
  always_comb begin
    tick_d = (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES_P - 1));
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic [31:0] group0_q, group0_d, group1_q, group1_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [DLY_W-1:0] delay_q, delay_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] status_w;
  logic [15:0] ratio_q [3];
  logic [15:0] ratio_d [3];
  logic [DLY_W-1:0] optime_q, optime_d;
  logic wr_en, mapped, writable;

  // decode, answer in the first access cycle
  always_comb begin
    wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    mapped = 1'b1;
    writable = 1'b0;
    prdata_d = prdata_q;
    unique case (paddr)
      OFF_GROUP0: begin
        prdata_d = group0_q;
        writable = 1'b1;
      end
      OFF_GROUP1: begin
        prdata_d = group1_q;
        writable = 1'b1;
      end
      OFF_CTRL: begin
        prdata_d = {29'h0, ctrl_q};
        writable = 1'b1;
      end
      OFF_DELAY: begin
        prdata_d = {13'h0, delay_q};
        writable = 1'b1;
      end
      OFF_STATUS: prdata_d = status_w;
      OFF_OPTIME: prdata_d = {13'h0, optime_q};
      OFF_REMAIN: prdata_d = {{12{tif.remain[REM_W-1]}}, tif.remain};
      OFF_RATIO0: prdata_d = {16'h0, ratio_q[0]};
      OFF_RATIO1: prdata_d = {16'h0, ratio_q[1]};
      OFF_RATIO2: prdata_d = {16'h0, ratio_q[2]};
      default: begin
        prdata_d = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
    pready_d = psel && !penable;
    pslverr_d = pready_d ? (!mapped || (pwrite && !writable)) : 1'b0;
    if (!pready_d) begin
      prdata_d = prdata_q;
    end
    group0_d = group0_q;
    group1_d = group1_q;
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    // new group values take effect on the next tick, supervision keeps running
    if (wr_en && paddr == OFF_GROUP0) begin
      group0_d = pwdata & GROUP_MASK;
    end
    if (wr_en && paddr == OFF_GROUP1) begin
      group1_d = pwdata & GROUP_MASK;
    end
    if (wr_en && paddr == OFF_CTRL) begin
      ctrl_d = pwdata[2:0];
    end
    if (wr_en && paddr == OFF_DELAY) begin
      delay_d = pwdata[DLY_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group0_q <= GROUP_RST;
      group1_q <= GROUP_RST;
      ctrl_q <= CTRL_RST;
      delay_q <= DELAY_RST;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      group0_q <= group0_d;
      group1_q <= group1_d;
      ctrl_q <= ctrl_d;
      delay_q <= delay_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // active setting group
  // ---------------------------------------------------------------
  logic [31:0] grp;
  logic [THR_W-1:0] low_thr, high_thr;
  logic [LIM_W-1:0] ang_lim;

  assign grp = ctrl_q[CTRL_GRP] ? group1_q : group0_q;
  assign low_thr = grp[LOW_LSB +: THR_W];
  assign high_thr = grp[HIGH_LSB +: THR_W];
  assign ang_lim = grp[LIM_LSB +: LIM_W];

  angle_tracker u_angle (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .angle(angle),
    .limit(ang_lim),
    .shift_seen(shift_seen)
  );

  op_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .t(tif)
  );

  // ---------------------------------------------------------------
  // supervision evaluation
  // ---------------------------------------------------------------
  logic pick_q, pick_d, start_q, start_d, blocked_q, blocked_d;
  logic alarm_q, alarm_d, disable_q, disable_d;
  logic bus_fail_q, bus_fail_d, line_fail_q, line_fail_d;
  cond_t cond_q, cond_d;
  bus_t bus_state_q, bus_state_d;
  logic [2:0] low_ph, high_ph;
  logic low_any, high_two, volt_cond, dead;
  logic [MAG_W-1:0] low_mag, high_mag;

  assign low_mag = MAG_W'(low_thr);
  assign high_mag = MAG_W'(high_thr);

  // magnitudes are in 0.01 nominal units, compared per phase
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign low_ph[p] = mag[p] < low_mag;
    assign high_ph[p] = mag[p] > high_mag;
    assign ratio_d[p] = !tick_q ? ratio_q[p] :
      (high_thr == '0) ? 16'hFFFF : 16'((32'(mag[p]) * 32'h64) / 32'(high_thr));
  end

  assign low_any = |low_ph;
  assign high_two = (high_ph[0] && high_ph[1]) || (high_ph[0] && high_ph[2])
                    || (high_ph[1] && high_ph[2]);
  assign volt_cond = low_any || high_two;
  assign dead = (&low_ph) && seq_pos < low_mag && seq_zero < low_mag && mag[3] < low_mag;

  // next state, taken only on the tick; alarm, disable and condition follow every cycle
  always_comb begin
    pick_d = pick_q;
    start_d = start_q;
    blocked_d = blocked_q;
    bus_fail_d = bus_fail_q;
    line_fail_d = line_fail_q;
    bus_state_d = bus_state_q;
    optime_d = optime_q;
    if (tick_q) begin
      // angle shift must be seen to enter pick-up, then voltage holds it
      pick_d = volt_cond && (pick_q || shift_seen);
      // block input is sampled per tick, so it must be present by the tick on which the delay expires
      if (!pick_d) begin
        start_d = 1'b0;
        blocked_d = 1'b0;
      end else if (block_in) begin
        start_d = 1'b0;
        blocked_d = 1'b1;
      end else begin
        start_d = !blocked_q;
      end
      bus_fail_d = ctrl_q[CTRL_BUS] && bus_breaker_trip_input;
      line_fail_d = ctrl_q[CTRL_LINE] && line_breaker_trip_input;
      optime_d = delay_q;
      if (pick_d) begin
        bus_state_d = BUS_PROBLEM;
      end else if (dead) begin
        bus_state_d = BUS_DEAD;
      end else if ({1'b0, seq_pos} > {seq_neg, 1'b0}) begin
        bus_state_d = BUS_OK;
      end else if ({1'b0, seq_neg} > {seq_pos, 1'b0}) begin
        bus_state_d = BUS_REV;
      end else begin
        bus_state_d = BUS_UNDEF;
      end
    end
    alarm_d = start_q && tif.expired;
    disable_d = alarm_d || bus_fail_q || line_fail_q;
    if (blocked_q) begin
      cond_d = COND_BLOCKED;
    end else if (line_fail_q) begin
      cond_d = COND_LINE_FAIL;
    end else if (bus_fail_q || alarm_q) begin
      cond_d = COND_BUS_FAIL;
    end else if (start_q) begin
      cond_d = COND_STARTED;
    end else begin
      cond_d = COND_NORMAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_q <= 1'b0;
      start_q <= 1'b0;
      blocked_q <= 1'b0;
      alarm_q <= 1'b0;
      disable_q <= 1'b0;
      bus_fail_q <= 1'b0;
      line_fail_q <= 1'b0;
      cond_q <= COND_NORMAL;
      bus_state_q <= BUS_DEAD;
      optime_q <= '0;
      for (int i = 0; i < 3; i++) begin
        ratio_q[i] <= '0;
      end
    end else begin
      pick_q <= pick_d;
      start_q <= start_d;
      blocked_q <= blocked_d;
      alarm_q <= alarm_d;
      disable_q <= disable_d;
      bus_fail_q <= bus_fail_d;
      line_fail_q <= line_fail_d;
      cond_q <= cond_d;
      bus_state_q <= bus_state_d;
      optime_q <= optime_d;
      ratio_q <= ratio_d;
    end
  end

  // timer runs while started, release resets it
  assign tif.tick = tick_q;
  assign tif.run = start_q;
  assign tif.delay = delay_q;

  assign status_w = {20'h0, alarm_q, blocked_q, start_q, pick_q, 1'b0, bus_state_q, 1'b0,
                     cond_q};
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign alarm = alarm_q;
  assign measurement_disable = disable_q;
  assign start = start_q;
  assign blocked = blocked_q;
  assign bus_transformer_failure = bus_fail_q;
  assign line_transformer_failure = line_fail_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_only_on_tick;
    !tick_q |=> $stable(start_q) && $stable(bus_state_q) && $stable(pick_q);
  endproperty
  a_only_on_tick: assert property (p_only_on_tick)
    else $error("state changed between ticks");

  property p_low_pick;
    tick_q && low_any && shift_seen |=> pick_q;
  endproperty
  a_low_pick: assert property (p_low_pick)
    else $error("low phase did not pick up");

  property p_angle_gate;
    tick_q && !pick_q && !shift_seen |=> !pick_q;
  endproperty
  a_angle_gate: assert property (p_angle_gate)
    else $error("pick-up without angle shift");

  property p_block_resets_start;
    tick_q && block_in |=> !start_q ##1 !alarm_q;
  endproperty
  a_block_resets_start: assert property (p_block_resets_start)
    else $error("start held under block");

  property p_problem_state;
    pick_q |-> bus_state_q == BUS_PROBLEM;
  endproperty
  a_problem_state: assert property (p_problem_state)
    else $error("pick-up without problem state");

  property p_bus_fuse;
    tick_q && bus_breaker_trip_input && ctrl_q[CTRL_BUS] |=> bus_fail_q ##1 disable_q;
  endproperty
  a_bus_fuse: assert property (p_bus_fuse)
    else $error("bus fuse failure missed");

  property p_line_off;
    tick_q && !ctrl_q[CTRL_LINE] |=> !line_fail_q;
  endproperty
  a_line_off: assert property (p_line_off)
    else $error("line fuse failure while check off");

  property p_cond_blocked;
    blocked_q |=> cond_q == COND_BLOCKED;
  endproperty
  a_cond_blocked: assert property (p_cond_blocked)
    else $error("blocked not shown in condition");

  c_alarm: cover property (start_q ##1 alarm_q);
  c_blocked: cover property (tick_q && block_in && volt_cond ##1 blocked_q);
  c_reversed: cover property (bus_state_q == BUS_REV);
endmodule
`default_nettype wire

// ### verif/front_end_model.sv
// measurement front end and fuse trip contacts feeding the supervision block
`timescale 1ns/1ns
`default_nettype none
module front_end_model
  import supervision_pkg::*;
(
  input wire logic pclk,
  input wire logic [3:0][MAG_W-1:0] w_mag,
  input wire logic [3:0][ANG_W-1:0] w_ang,
  input wire logic [MAG_W-1:0] w_pos,
  input wire logic [MAG_W-1:0] w_neg,
  input wire logic [MAG_W-1:0] w_zero,
  input wire logic w_btrip,
  input wire logic w_ltrip,
  output logic [3:0][MAG_W-1:0] mag,
  output logic [3:0][ANG_W-1:0] angle,
  output logic [MAG_W-1:0] seq_pos,
  output logic [MAG_W-1:0] seq_neg,
  output logic [MAG_W-1:0] seq_zero,
  output logic btrip,
  output logic ltrip
);
  // refresh faster than the 5 ms time base, so every tick sees fresh values
  always @(posedge pclk) begin
    mag <= w_mag;
    angle <= w_ang;
    seq_pos <= w_pos;
    seq_neg <= w_neg;
    seq_zero <= w_zero;
    btrip <= w_btrip;
    ltrip <= w_ltrip;
  end
endmodule
`default_nettype wire

// ### verif/tb_voltage_supervision.sv
// self-checking bench for the voltage supervision block
`timescale 1ns/1ns
`default_nettype none
module tb_voltage_supervision;
  import supervision_pkg::*;
  localparam int TK = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blk = 0;
  logic pready, pslverr, er, alarm, mdis, start, blocked, bfail, lfail, btrip, ltrip;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0][MAG_W-1:0] w_mag = '0, mag;
  logic [3:0][ANG_W-1:0] w_ang = '0, angle;
  logic [MAG_W-1:0] w_pos = 0, w_neg = 0, w_zero = 0, seq_pos, seq_neg, seq_zero;
  logic w_btrip = 0, w_ltrip = 0;
  int failures = 0, total_checks = 0, cyc = 0, seed = 64883, i, m, n;
  int pos_t[3] = '{100, 10, 100};
  int neg_t[3] = '{0, 100, 100};
  always #50 pclk = ~pclk;
  voltage_supervision #(.TICK_CYCLES_P(TK)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mag(mag), .angle(angle),
    .seq_pos(seq_pos), .seq_neg(seq_neg), .seq_zero(seq_zero),
    .bus_breaker_trip_input(btrip), .line_breaker_trip_input(ltrip), .block_in(blk),
    .alarm(alarm), .measurement_disable(mdis), .start(start), .blocked(blocked),
    .bus_transformer_failure(bfail), .line_transformer_failure(lfail));
  front_end_model fe_u (.pclk(pclk), .w_mag(w_mag), .w_ang(w_ang), .w_pos(w_pos),
    .w_neg(w_neg), .w_zero(w_zero), .w_btrip(w_btrip), .w_ltrip(w_ltrip), .mag(mag),
    .angle(angle), .seq_pos(seq_pos), .seq_neg(seq_neg), .seq_zero(seq_zero),
    .btrip(btrip), .ltrip(ltrip));
  // reference model of ratio and bus sequence state
  function automatic int ratio_exp(int mv, int hv);
    return (hv == 0) ? 32'hFFFF : mv * 100 / hv;
  endfunction
  function automatic int bus_exp(int p, int q);
    return (p > 2 * q) ? 1 : ((q > 2 * p) ? 2 : 3);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 50) chk(0, 1, "apb hang");
    @(posedge pclk);
  endtask
  task automatic ticks(input int k);
    repeat (k * TK) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      report_and_stop;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, OFF_GROUP0, 0); chk(rd, GROUP_RST, "group0 reset");
    apb(0, OFF_CTRL, 0); chk(rd, 32'h00000006, "ctrl reset");
    apb(0, OFF_DELAY, 0); chk(rd, 32'h000000C8, "delay reset");
    apb(0, 8'h40, 0); chk({er, rd[30:0]}, 32'h80000000, "unmapped");
    apb(1, OFF_STATUS, 32'h00000FFF); chk(er, 1, "read only write");
    ticks(3);
    apb(0, OFF_STATUS, 0); chk(rd[8:4], 5'h00, "dead bus");
    $display("registers and dead bus done");
    for (i = 0; i < 3; i++) begin
      m = 90 + ($random(seed) & 15);
      w_mag <= {4{m[11:0]}};
      w_pos <= pos_t[i][11:0];
      w_neg <= neg_t[i][11:0];
      ticks(3);
      apb(0, OFF_STATUS, 0); chk(rd[6:4], bus_exp(pos_t[i], neg_t[i]), "bus state");
      apb(0, OFF_RATIO0, 0); chk(rd, ratio_exp(m, 80), "ratio");
    end
    apb(1, OFF_GROUP1, 32'h00323205);
    apb(1, OFF_CTRL, 32'h00000007);
    ticks(2);
    apb(0, OFF_RATIO1, 0); chk(rd, ratio_exp(m, 50), "group1 ratio");
    apb(1, OFF_CTRL, 32'h00000006);
    w_btrip <= 1;
    w_ltrip <= 1;
    ticks(2);
    chk({bfail, lfail}, 2'b11, "fuse fail");
    apb(1, OFF_CTRL, 0);
    ticks(2);
    chk({bfail, lfail}, 2'b00, "fuse check off");
    w_btrip <= 0;
    w_ltrip <= 0;
    apb(1, OFF_CTRL, 32'h00000006);
    apb(1, OFF_DELAY, 32'h00000003);
    $display("sequence, group and fuse done");
    w_mag[0] <= 2;
    w_ang[0] <= 900;
    n = 0;
    while (start !== 1'b1 && n < 10 * TK) begin
      @(posedge pclk);
      n++;
    end
    chk({start, alarm}, 2'b10, "start before delay");
    apb(0, OFF_OPTIME, 0); chk(rd, 32'h00000003, "op time");
    ticks(4);
    chk({alarm, mdis}, 2'b11, "alarm and disable");
    apb(0, OFF_REMAIN, 0); chk(rd, 0, "remain at expiry");
    apb(0, OFF_STATUS, 0); chk(rd[6:4], BUS_PROBLEM, "problem bus");
    w_mag <= {4{12'h046}};
    ticks(2);
    chk(start, 0, "recovered");
    blk <= 1; // raised ticks before the delay would end
    w_mag[0] <= 2;
    w_ang[0] <= 0;
    ticks(4);
    chk({blocked, start}, 2'b10, "blocked pickup");
    apb(0, OFF_STATUS, 0); chk(rd[2:0], COND_BLOCKED, "blocked cond");
    $display("fault and block done");
    report_and_stop;
  end
endmodule
`default_nettype wire
